// >>> rtl/cache_xlate.sv
// cache, tag memory, page translation table and ready combiner
`timescale 1ns/1ns
module cache_xlate
  import cache_xlate_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // processor cycle
  input  wire logic        cpu_start,
  input  wire logic        cpu_is_bio,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic [1:0]  cpu_be,
  input  wire logic [15:0] cpu_wdata,
  output logic             cpu_ready,
  output logic [15:0]      cpu_rdata,
  // other ready source and control latch bits
  input  wire logic        local_cycle_done,
  input  wire logic        cache_on,
  input  wire logic        force_bus_wr,
  // system bus, foreign domain
  input  wire logic        bus_owned,
  input  wire logic        early_transfer_ack,
  input  wire logic        bus_xack,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        snoop_wr,
  input  wire logic [23:0] snoop_addr,
  output logic             cache_bus_want,
  output logic             bus_mem_rd,
  output logic             bus_mem_wr,
  output logic             bus_io_rd,
  output logic             bus_io_wr,
  output logic [23:0]      bus_addr,
  output logic [15:0]      bus_wdata,
  output logic [1:0]       bus_be
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic kind_t kind_of(input logic [23:0] a, input logic bio);
    if (bio)
      kind_of = K_BIO;
    else if (a[23:11] == XL_BASE[23:11])
      kind_of = K_XL;
    else if (a[23:11] == TAG_BASE[23:11])
      kind_of = K_TAG;
    else if (a[23:13] == CRAM_BASE[23:13])
      kind_of = K_CRAM;
    else if (a[23:22] == LOW_REGION)
      kind_of = K_MEM;
    else
      kind_of = K_NONE;
  endfunction : kind_of

  // byte lanes only matter for local RAM, cache data and general; tag and table take whole words
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [11:0] xl_mem  [XL_ENTRIES];
  logic [12:0] tag_mem [XL_ENTRIES];
  logic [15:0] lram    [LRAM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the bus side

  logic [1:0]  own_s;
  logic [1:0]  eack_s;
  logic [1:0]  xack_s;
  logic [1:0]  snp_s;
  logic [23:0] snpa_s0;
  logic [23:0] snpa_s1;
  logic [31:0] rd_s0;
  logic [31:0] rd_s1;
  logic        snp_d;

  always_ff @(posedge clk)
  begin
    own_s   <= {own_s[0], bus_owned};
    eack_s  <= {eack_s[0], early_transfer_ack};
    xack_s  <= {xack_s[0], bus_xack};
    snp_s   <= {snp_s[0], snoop_wr};
    snpa_s0 <= snoop_addr;
    snpa_s1 <= snpa_s0;
    rd_s0   <= bus_rdata;
    rd_s1   <= rd_s0;
    snp_d   <= snp_s[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // request latch and lookup

  state_t      st;
  state_t      st_next;
  kind_t       kind;
  logic [23:0] a_reg;
  logic        wr_reg;
  logic [1:0]  be_reg;
  logic [15:0] wd_reg;

  always_ff @(posedge clk)
  begin
    if (st == ST_IDLE && cpu_start)
    begin
      kind   <= kind_of(cpu_addr, cpu_is_bio);
      a_reg  <= cpu_addr;
      wr_reg <= cpu_write;
      be_reg <= cpu_be;
      wd_reg <= cpu_wdata;
    end
  end

  wire         in_look = (st == ST_LOOK);
  wire         in_bus  = (st == ST_BUS);
  wire         in_fill = (st == ST_FILL);
  wire [9:0]   io_idx  = a_reg[10:1];
  wire [11:0]  page    = xl_mem[a_reg[21:12]];           // see (R2) (R19)
  wire [23:0]  phys    = {page, a_reg[11:0]};           // see (R1) (R3)
  wire [9:0]   line    = a_reg[11:2];                   // see (R9)
  wire [12:0]  tag_rd  = tag_mem[line];
  wire [11:0]  cw      = {1'b0, line, a_reg[1]};        // see (R8)
  wire [11:0]  fw0     = {1'b0, line, 1'b0};
  wire [11:0]  fw1     = {1'b0, line, 1'b1};
  wire         is_mem  = (kind == K_MEM);
  wire         tag_hit = (tag_rd[TAG_INV_B] == TAG_VALID)
                         && (tag_rd[11:0] == page);     // see (R6) (R17)
  wire         hit     = cache_on && tag_hit;           // see (R21)
  wire         rd_hit  = is_mem && !wr_reg && hit && !force_bus_wr;  // see (R10)
  wire         wr_hit  = is_mem && wr_reg && hit;                   // see (R11)
  wire         do_fill = is_mem && !wr_reg && cache_on && !force_bus_wr;
  wire         bus_wr  = wr_reg || (is_mem && force_bus_wr);        // see (R22)
  wire         bio     = (kind == K_BIO);

  ////////////////////////////////////////////////////////////////////////////
  // bus command phases

  logic cmd_on;
  logic cmd_ph2;
  logic eack_used;
  logic [15:0] fill_hi;

  wire bus_end  = in_bus && cmd_ph2 && xack_s[1];
  wire eack_rdy = in_bus && cmd_ph2 && eack_s[1] && bus_wr && !eack_used;  // see (R18)
  wire cmd_next = in_bus && !bus_end && (cmd_on || (own_s[1] && !xack_s[1]));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_on    <= 1'b0;
      cmd_ph2   <= 1'b0;
      eack_used <= 1'b0;
    end
    else
    begin
      cmd_on    <= cmd_next;
      cmd_ph2   <= cmd_next && cmd_on;
      eack_used <= (st != ST_IDLE) && (eack_used || eack_rdy);
    end
  end

  always_ff @(posedge clk)
  begin
    if (bus_end)
      fill_hi <= rd_s1[31:16];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  logic tbl_done;
  logic cch_done;

  always_comb
  begin
    st_next  = st;
    tbl_done = 1'b0;
    cch_done = 1'b0;
    case (st)
      ST_IDLE:
        if (cpu_start && kind_of(cpu_addr, cpu_is_bio) != K_NONE)
          st_next = ST_LOOK;                           // see (R5) (R14)
      ST_LOOK:
        case (kind)
          K_XL, K_TAG:
          begin
            tbl_done = 1'b1;                           // see (R7)
            st_next  = ST_IDLE;
          end
          K_CRAM:
          begin
            cch_done = 1'b1;
            st_next  = ST_IDLE;
          end
          K_MEM:
          begin
            cch_done = rd_hit;
            st_next  = rd_hit ? ST_IDLE : ST_BUS;
          end
          K_BIO:
            st_next = ST_BUS;
          default:
            st_next = ST_IDLE;
        endcase
      ST_BUS:
        if (bus_end)
        begin
          st_next  = do_fill ? ST_FILL : ST_IDLE;
          cch_done = !do_fill && !eack_used;
        end
      ST_FILL:
      begin
        cch_done = 1'b1;
        st_next  = ST_IDLE;
      end
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= ST_IDLE;                                   // see (R24)
    else
      st <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // snoop search; a pending snoop waits out any processor tag write

  logic        snp_pend;
  wire         snp_rise = snp_s[1] && !snp_d;           // see (R5)
  wire [9:0]   snp_line = snpa_s1[11:2];
  wire [12:0]  snp_tag  = tag_mem[snp_line];
  wire         snp_hit  = (snp_tag[TAG_INV_B] == TAG_VALID)
                          && (snp_tag[11:0] == snpa_s1[23:12]);
  wire         fsm_tagw = (in_look && kind == K_TAG && wr_reg) || in_fill;
  wire         snp_clr  = snp_pend && !fsm_tagw;        // see (R23)
  wire         snp_inv  = snp_clr && snp_hit;           // see (R12)

  // a new snoop edge in the clearing cycle keeps the flag set
  always_ff @(posedge clk)
  begin
    if (rst)
      snp_pend <= 1'b0;
    else
      snp_pend <= snp_rise || (snp_pend && !snp_clr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory write ports

  wire        xl_we  = in_look && kind == K_XL && wr_reg;            // see (R7)
  wire        tag_we = fsm_tagw || snp_inv;
  wire [9:0]  tag_wa = in_fill ? line : (fsm_tagw ? io_idx : snp_line);
  wire [12:0] tag_wd = in_fill  ? {TAG_VALID, page}                 // see (R9)
                     : fsm_tagw ? wd_reg[12:0]
                     : {TAG_INVAL, snp_tag[11:0]};
  wire        cram_w = in_look && kind == K_CRAM && wr_reg;          // see (R15)
  wire        cpu_w  = cram_w || (in_look && wr_hit);
  wire        fill_w = bus_end && do_fill;
  wire [11:0] cpu_wa = cram_w ? a_reg[12:1] : cw;
  wire        ram_we = cpu_w || fill_w || in_fill;
  wire [11:0] ram_wa = cpu_w ? cpu_wa : (in_fill ? fw1 : fw0);
  wire [15:0] ram_wd = cpu_w  ? merge(lram[cpu_wa], wd_reg, be_reg)  // see (R16)
                     : in_fill ? fill_hi : rd_s1[15:0];              // see (R10)

  always_ff @(posedge clk)
  begin
    if (xl_we)
      xl_mem[io_idx] <= wd_reg[11:0];                 // see (R4)
    if (tag_we)
      tag_mem[tag_wa] <= tag_wd;
    if (ram_we)
      lram[ram_wa] <= ram_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and ready combiner

  logic [15:0] rdata_next;

  always_comb
  begin
    rdata_next = cpu_rdata;
    if (in_look)
      case (kind)
        K_XL:    rdata_next = {4'h0, xl_mem[io_idx]};
        K_TAG:   rdata_next = {3'h0, tag_mem[io_idx]};
        K_CRAM:  rdata_next = lram[a_reg[12:1]];
        K_MEM:   rdata_next = rd_hit ? lram[cw] : cpu_rdata;
        default: rdata_next = cpu_rdata;
      endcase
    else if (bus_end && !bus_wr)
      rdata_next = a_reg[1] ? rd_s1[31:16] : rd_s1[15:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_ready <= 1'b0;
      cpu_rdata <= 16'h0000;
    end
    else
    begin
      cpu_ready <= local_cycle_done || tbl_done || cch_done || eack_rdy;  // see (R18)
      cpu_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system bus outputs

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cache_bus_want <= 1'b0;
      bus_mem_rd     <= 1'b0;
      bus_mem_wr     <= 1'b0;
      bus_io_rd      <= 1'b0;
      bus_io_wr      <= 1'b0;
      bus_addr       <= 24'h000000;
      bus_wdata      <= 16'h0000;
      bus_be         <= 2'h0;
    end
    else
    begin
      cache_bus_want <= (st_next == ST_BUS) && !own_s[1];            // see (R13)
      bus_mem_rd     <= cmd_next && !bio && !bus_wr;
      bus_mem_wr     <= cmd_next && !bio && bus_wr;                  // see (R11)
      bus_io_rd      <= cmd_next && bio && !wr_reg;
      bus_io_wr      <= cmd_next && bio && wr_reg;
      if (in_look)
      begin
        bus_addr  <= bio ? {8'h00, a_reg[15:0]} : phys;
        bus_wdata <= wd_reg;
        bus_be    <= be_reg;
      end
    end
  end

endmodule : cache_xlate

// >>> include/cache_xlate_pkg.sv
// constants and types for the cache and address translation block
//
// Functional notes
// (R1) System address is table output above processor address bits 0..11 passed straight.
// (R2) Translation table has 1024 entries, each mapping one 4K page by page number.
// (R3) Entry bits 0..11 drive system address bits 12..23 in ascending order.
// (R4) Software touches translation entries only with 16-bit transfers, never bytes.
// (R5) Tag machine starts on processor memory, tag/table I/O and foreign memory writes.
// (R6) On processor memory cycles stored tag equal to translated page gives a hit.
// (R7) Tag/table I/O cycles produce the buffer enables and RAM strobes for those memories.
// (R8) Cache is 4K direct mapped, 4-byte lines, code and data from 16M space.
// (R9) Offset field picks line and tag; a fill loads the source page number.
// (R10) Read hit served from cache; read miss reads memory, fills line, updates tag.
// (R11) Write hit writes cache and memory; write miss writes memory only.
// (R12) Every foreign memory write is searched; a hit marks that tag invalid.
// (R13) Without bus ownership, request bus for bus I/O, memory writes, read misses.
// (R14) Cache machine starts on cache RAM I/O, bus memory or bus I/O; ends at ready; an early-acked write ends only at bus_xack, after ready.
// (R15) 8K local RAM: 4K cache data, 4K general, all reachable by cache RAM I/O.
// (R16) Tag memory only 16-bit transfers; cache data allows byte or word transfers.
// (R17) Tag entry: page number in bits 0..11, bit 12 is 0 valid, 1 invalid.
// (R18) Ready on any controller done, or early ack in second command phase; early ack gives ready on write cycles only; code also on force_bus_wr reads.
// (R19) Table can place lowest 4M of processor space anywhere in system space.
// (R20) Software invalidates all tags and loads the table before enabling cache.
// (R21) Cache enable bit, clear at reset; when 0 all accesses bypass the cache.
// (R22) A control bit forces a system bus write when a cache search occurs.
// (R23) Snoop invalidation colliding with a processor tag access is serialised, never lost.
// (R24) Each controller returns to idle after a cycle and is forced idle by reset.
package cache_xlate_pkg;
  localparam int          ADDR_W     = 24;
  localparam int          PAGE_W     = 12;
  localparam int          XL_ENTRIES = 1024;
  localparam int          LRAM_WORDS = 4096;
  localparam logic [23:0] XL_BASE    = 24'h400800;
  localparam logic [23:0] TAG_BASE   = 24'h401000;
  localparam logic [23:0] CRAM_BASE  = 24'h402000;
  localparam int          TAG_INV_B  = 12;
  localparam logic        TAG_VALID  = 1'b0;
  localparam logic        TAG_INVAL  = 1'b1;
  localparam logic [1:0]  LOW_REGION = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_BUS  = 2'b11,
    ST_FILL = 2'b10
  } state_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_XL   = 3'h1,
    K_TAG  = 3'h2,
    K_CRAM = 3'h3,
    K_MEM  = 3'h4,
    K_BIO  = 3'h5
  } kind_t;
endpackage : cache_xlate_pkg

// >>> verification/cache_xlate_sva.sv
// port assertions for the cache and translation block
`timescale 1ns/1ns
module cache_xlate_sva
  import cache_xlate_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // processor side
  input wire logic        cpu_start,
  input wire logic        cpu_is_bio,
  input wire logic [23:0] cpu_addr,
  input wire logic        cpu_ready,
  input wire logic        local_cycle_done,
  // system bus side
  input wire logic        bus_owned,
  input wire logic        cache_bus_want,
  input wire logic        bus_mem_rd,
  input wire logic        bus_mem_wr,
  input wire logic        bus_io_rd,
  input wire logic        bus_io_wr,
  input wire logic [23:0] bus_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  wire io_cmd = bus_io_rd | bus_io_wr;
  wire in_xl  = cpu_addr[23:11] == XL_BASE[23:11];
  wire in_tag = cpu_addr[23:11] == TAG_BASE[23:11];
  wire in_ram = cpu_addr[23:13] == CRAM_BASE[23:13];
  wire io_go  = cpu_start & ~cpu_is_bio & (in_xl | in_tag | in_ram);
  sequence s_rd_held;
    bus_mem_rd [*3];
  endsequence
  sequence s_owned;
    bus_owned [*4];
  endsequence
  ////////////////////////////////////////
  AST_READY_PULSE: assert property (cpu_ready |=> !cpu_ready)
    else $error("ready longer than one cycle");
  AST_LOCAL_READY: assert property (local_cycle_done |=> cpu_ready)
    else $error("local done not passed to ready");
  AST_IO_ANSWER: assert property (io_go |-> ##[2:3] cpu_ready)
    else $error("table, tag or ram access not answered");
  AST_NO_WANT_OWNED: assert property (s_owned |-> !cache_bus_want)
    else $error("bus wanted while owned");
  AST_ONE_CMD: assert property ($onehot0({bus_mem_rd, bus_mem_wr, io_cmd, bus_io_rd & bus_io_wr}))
    else $error("two bus commands at once");
  AST_IO_ADDR: assert property (io_cmd |-> bus_addr[23:16] == 8'h00)
    else $error("bus io address above 16 bits");
  AST_RD_HELD: assert property ($rose(bus_mem_rd) |-> s_rd_held)
    else $error("memory read dropped early");
  AST_FILL_DONE: assert property ($fell(bus_mem_rd) |-> ##[0:2] cpu_ready)
    else $error("read not completed after command");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    rst |=> !cpu_ready && !cache_bus_want && !bus_mem_rd && !bus_mem_wr && !io_cmd)
    else $error("outputs active after reset");
endmodule : cache_xlate_sva

bind cache_xlate cache_xlate_sva chk (.clk(clk), .rst(rst), .cpu_start(cpu_start),
  .cpu_is_bio(cpu_is_bio), .cpu_addr(cpu_addr), .cpu_ready(cpu_ready),
  .local_cycle_done(local_cycle_done), .bus_owned(bus_owned),
  .cache_bus_want(cache_bus_want), .bus_mem_rd(bus_mem_rd), .bus_mem_wr(bus_mem_wr),
  .bus_io_rd(bus_io_rd), .bus_io_wr(bus_io_wr), .bus_addr(bus_addr));

// >>> verification/sys_bus_model.sv
// system bus memory and io responder facing the cache block
`timescale 1ns/1ns
module sys_bus_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // 1 stretches the acknowledge
  input  wire logic        slow,
  // commands from the block
  input  wire logic        bus_mem_rd,
  input  wire logic        bus_mem_wr,
  input  wire logic        bus_io_rd,
  input  wire logic        bus_io_wr,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  // slave answers
  output logic             early_transfer_ack,
  output logic             bus_xack,
  output logic [31:0]      bus_rdata,
  // record of the last command
  output logic [7:0]       cmd_count,
  output logic [3:0]       last_kind,
  output logic [23:0]      last_addr,
  output logic [15:0]      last_wdata
);
  logic [3:0] age_reg;
  wire  [3:0] kind   = {bus_mem_rd, bus_mem_wr, bus_io_rd, bus_io_wr};
  wire        busy   = |kind;
  wire  [3:0] ack_at = slow ? 4'h6 : 4'h2;
  ////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      age_reg <= 4'h0;
      bus_xack <= 1'b0;
      early_transfer_ack <= 1'b0;
      bus_rdata <= 32'h0;
      cmd_count <= 8'h0;
    end
    else
    begin
      age_reg <= busy ? age_reg + 4'h1 : 4'h0;
      bus_xack <= busy & (age_reg >= ack_at);
      early_transfer_ack <= busy & (age_reg >= ack_at - 4'h1);
      // released data lines keep toggling so stale data cannot pass
      bus_rdata <= (bus_mem_rd | bus_io_rd) ?
        {bus_addr[15:2], 2'b11, bus_addr[15:2], 2'b01} : ~bus_rdata;
      if (busy & (age_reg == 4'h0))
      begin
        cmd_count <= cmd_count + 8'h1;
        last_kind <= kind;
        last_addr <= bus_addr;
        last_wdata <= bus_wdata;
      end
    end
  end
endmodule : sys_bus_model

// >>> verification/cache_xlate_tb.sv
// self-checking bench for the cache and translation block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module cache_xlate_tb
  import cache_xlate_pkg::*;
;
  localparam logic [23:0] CPU_A = 24'h005124;
  localparam logic [23:0] SYS_A = 24'hab3124;
  localparam logic [23:0] TAG_A = TAG_BASE + 24'h92;
  localparam logic [23:0] RAM_A = CRAM_BASE + 24'h124;
  logic clk = 0, rst = 1, cpu_start = 0, cpu_is_bio = 0, cpu_write = 0, cpu_ready;
  logic local_cycle_done = 0, cache_on = 0, force_bus_wr = 0, bus_owned = 1, snoop_wr = 0;
  logic slow = 0, early_transfer_ack, bus_xack, cache_bus_want;
  logic bus_mem_rd, bus_mem_wr, bus_io_rd, bus_io_wr;
  logic [1:0] cpu_be = 0, bus_be;
  logic [3:0] last_kind;
  logic [7:0] cmd_count, c0;
  logic [15:0] cpu_wdata = 0, cpu_rdata, bus_wdata, last_wdata, q;
  logic [23:0] cpu_addr = 0, snoop_addr = 0, bus_addr, last_addr;
  logic [31:0] bus_rdata;
  int fail_count = 0, num_checks = 0, n;
  always #2 clk = ~clk;
  cache_xlate dut (.clk(clk), .rst(rst), .cpu_start(cpu_start), .cpu_is_bio(cpu_is_bio),
    .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_be(cpu_be), .cpu_wdata(cpu_wdata),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .local_cycle_done(local_cycle_done),
    .cache_on(cache_on), .force_bus_wr(force_bus_wr), .bus_owned(bus_owned),
    .early_transfer_ack(early_transfer_ack), .bus_xack(bus_xack), .bus_rdata(bus_rdata),
    .snoop_wr(snoop_wr), .snoop_addr(snoop_addr), .cache_bus_want(cache_bus_want),
    .bus_mem_rd(bus_mem_rd), .bus_mem_wr(bus_mem_wr), .bus_io_rd(bus_io_rd),
    .bus_io_wr(bus_io_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be));
  sys_bus_model far (.clk(clk), .rst(rst), .slow(slow), .bus_mem_rd(bus_mem_rd),
    .bus_mem_wr(bus_mem_wr), .bus_io_rd(bus_io_rd), .bus_io_wr(bus_io_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .early_transfer_ack(early_transfer_ack),
    .bus_xack(bus_xack), .bus_rdata(bus_rdata), .cmd_count(cmd_count),
    .last_kind(last_kind), .last_addr(last_addr), .last_wdata(last_wdata));
  ////////////////////////////////////////
  function automatic logic [15:0] pat(input logic [23:0] a);
    return a[1] ? {a[15:2], 2'b11} : {a[15:2], 2'b01};
  endfunction : pat
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  // one processor cycle; n counts edges up to ready, 2 means the short answer
  task automatic op(input logic [23:0] a, input logic w, input logic [1:0] be,
                    input logic [15:0] d);
    // an early-acked write answers before its command ends; a start then would be dropped
    while ((bus_mem_rd | bus_mem_wr | bus_io_rd | bus_io_wr) === 1'b1) tick(1);
    cpu_addr = a;
    cpu_write = w;
    cpu_be = be;
    cpu_wdata = d;
    cpu_start = 1;
    tick(1);
    cpu_start = 0;
    n = 1;
    while (cpu_ready !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    q = cpu_rdata;
    if (n >= 300) fail_count++;
  endtask : op
  task automatic snoop(input logic [23:0] a);
    snoop_addr = a;
    tick(3);
    snoop_wr = 1;
    tick(4);
    snoop_wr = 0;
    tick(4);
  endtask : snoop
  ////////////////////////////////////////
  task automatic t_tables;
    op(XL_BASE + 24'ha, 1, 2'b11, 16'h0ab3);
    op(XL_BASE + 24'hc, 1, 2'b11, 16'h0ab4);
    op(XL_BASE + 24'ha, 0, 2'b11, 0);
    `CHK("table entry", 16'h0ab3, q)
    `CHK("table answer", 1'b1, n <= 3)
    op(TAG_A, 1, 2'b11, 16'h1fff);
    op(TAG_A, 0, 2'b11, 0);
    `CHK("tag entry", 16'h1fff, q)
    op(CRAM_BASE + 24'h1000, 1, 2'b11, 16'h1234);
    op(CRAM_BASE + 24'h1000, 1, 2'b01, 16'h00ff);
    op(CRAM_BASE + 24'h1000, 0, 2'b11, 0);
    `CHK("general ram", 16'h12ff, q)
  endtask : t_tables
  task automatic t_fill;
    cache_on = 1;
    op(CPU_A, 0, 2'b11, 0);
    c0 = cmd_count;
    `CHK("miss address", SYS_A, last_addr)
    `CHK("miss kind", 4'b1000, last_kind)
    `CHK("miss data", pat(SYS_A), q)
    op(TAG_A, 0, 2'b11, 0);
    `CHK("filled tag", 16'h0ab3, q)
    op(CPU_A + 24'h2, 0, 2'b11, 0);
    `CHK("hit data", pat(SYS_A + 24'h2), q)
    `CHK("hit answer", 1'b1, n <= 3)
    `CHK("hit bus idle", c0, cmd_count)
  endtask : t_fill
  task automatic t_write;
    slow = 1;
    op(CPU_A, 1, 2'b11, 16'hbeef);
    `CHK("hit bus data", 16'hbeef, last_wdata)
    op(RAM_A, 0, 2'b11, 0);
    `CHK("hit line", 16'hbeef, q)
    op(24'h006124, 1, 2'b11, 16'h1111);
    `CHK("miss bus address", 24'hab4124, last_addr)
    op(RAM_A, 0, 2'b11, 0);
    `CHK("miss line", 16'hbeef, q)
    slow = 0;
    cache_on = 0;
    c0 = cmd_count;
    op(CPU_A, 0, 2'b11, 0);
    `CHK("bypass read", c0 + 8'h1, cmd_count)
    cache_on = 1;
    force_bus_wr = 1;
    op(CPU_A, 0, 2'b11, 16'h5a5a);
    force_bus_wr = 0;
    `CHK("forced kind", 4'b0100, last_kind)
    `CHK("forced data", 16'h5a5a, last_wdata)
  endtask : t_write
  task automatic t_snoop;
    snoop(24'hab4124);
    op(TAG_A, 0, 2'b11, 0);
    `CHK("tag kept", 16'h0ab3, q)
    snoop(SYS_A);
    op(TAG_A, 0, 2'b11, 0);
    `CHK("tag dropped", 16'h1ab3, q)
  endtask : t_snoop
  // the block has to ask for the bus it does not own
  task automatic t_io;
    bus_owned = 0;
    cpu_is_bio = 1;
    fork
      op(24'h50c456, 1, 2'b11, 16'h0f0f);
      begin
        for (int k = 0; k < 50 && cache_bus_want !== 1'b1; k++) tick(1);
        `CHK("bus want", 1'b1, cache_bus_want)
        bus_owned = 1;
      end
    join
    cpu_is_bio = 0;
    `CHK("io address", 24'h00c456, last_addr)
    `CHK("io kind", 4'b0001, last_kind)
    // let the io ready pulse end so the two pulses stay apart
    tick(1);
    local_cycle_done = 1;
    tick(1);
    local_cycle_done = 0;
    `CHK("local ready", 1'b1, cpu_ready)
    tick(2);
    rst = 1;
    tick(2);
    rst = 0;
    op(XL_BASE + 24'ha, 0, 2'b11, 0);
    `CHK("after reset", 16'h0ab3, q)
  endtask : t_io
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    #80000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    tick(16);
    rst = 0;
    t_tables();
    t_fill();
    t_write();
    t_snoop();
    t_io();
    complete_run();
  end
endmodule : cache_xlate_tb
